// file: common/aspc_pkg.sv
/*
  Shared constants and types for the converter serial port and configuration control block.
  Assumes a single 40 MHz system clock. All pins from outside that clock are synchronised first.
*/
package aspc_pkg;

  // widths
  localparam int RES_BITS = 16;
  localparam int CFG_BITS = 8;
  localparam int SYNC_BITS = 15;
  localparam int PIN_HI_BASE = 11;

  // values after reset
  localparam logic [CFG_BITS-1:0]  CFG_RESET  = 8'h00;
  localparam logic [RES_BITS-1:0]  RES_RESET  = 16'h0000;
  localparam logic [SYNC_BITS-1:0] SYNC_RESET = 15'h4180;

  // serial configuration word fields
  localparam int CFG_WIDE_POS    = 0;
  localparam int CFG_BIPOLAR_POS = 1;
  localparam int CFG_POL_POS     = 2;
  localparam int CFG_RDC_POS     = 3;

  // cycle and bit counts
  localparam logic [3:0] CFG_CNT_FULL = 4'h8;
  localparam logic [4:0] RES_CNT_LAST = 5'h0F;
  localparam logic [1:0] MCLK_HALF    = 2'h1;

  // synchroniser lane positions
  localparam int SY_SERPAR  = 0;
  localparam int SY_CLKSRC  = 1;
  localparam int SY_POL     = 2;
  localparam int SY_INV     = 3;
  localparam int SY_RDC     = 4;
  localparam int SY_BIPOLAR = 5;
  localparam int SY_WIDE    = 6;
  localparam int SY_CS_N    = 7;
  localparam int SY_RD_N    = 8;
  localparam int SY_RESET   = 9;
  localparam int SY_SCLK    = 10;
  localparam int SY_CFGSRC  = 11;
  localparam int SY_CFGDAT  = 12;
  localparam int SY_CFGCLK  = 13;
  localparam int SY_CFGCS_N = 14;

  typedef enum logic [1:0] {
    RANGE_0_5,
    RANGE_0_10,
    RANGE_PM5,
    RANGE_PM10
  } aspc_range_type;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_MASTER,
    RD_SLAVE
  } aspc_rd_state_type;

endpackage

// file: common/aspc_cfg_if.sv
/*
  Carrier between the top block and the serial configuration port.
  Assumes all signals are already synchronised to the system clock.
*/
`timescale 1ns/1ps
interface aspc_cfg_if;
  logic                          sclk;
  logic                          sdata;
  logic                          cs_n;
  logic                          enable;
  logic                          invert;
  logic                          clear;
  logic [aspc_pkg::CFG_BITS-1:0] word;

  modport top (output sclk, output sdata, output cs_n, output enable,
               output invert, output clear, input word);
  modport cfg (input sclk, input sdata, input cs_n, input enable,
               input invert, input clear, output word);
endinterface

// file: design/aspc_sync.sv
/*
  Two flip-flop synchroniser bank with a per-lane value after reset.
  Assumes inputs are asynchronous to clock; only the second stage is read.
*/
`timescale 1ns/1ps
module aspc_sync #(
  parameter int                   WIDTH = 1,
  parameter logic [WIDTH-1:0]     INIT  = '0
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } aspc_sync_type;

  aspc_sync_type st_r;
  aspc_sync_type st_nxt;

  always_comb begin
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{s1: INIT, s2: INIT};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.s2;

endmodule

// file: design/aspc_cfg_port.sv
/*
  Serial configuration port: shifts the word in, MSB first, on the selected clock edge.
  Assumes synchronised inputs via the carrier; the word is committed when chip select releases.
*/
`timescale 1ns/1ps
module aspc_cfg_port (
  input  wire logic clock,
  input  wire logic reset_n,
  aspc_cfg_if.cfg   cfg_if
);

  typedef struct packed {
    logic                          sclk_q;
    logic                          cs_q;
    logic [3:0]                    cnt;
    logic [aspc_pkg::CFG_BITS-1:0] shreg;
    logic [aspc_pkg::CFG_BITS-1:0] word;
  } aspc_cfg_type;

  aspc_cfg_type st_r;
  aspc_cfg_type st_nxt;
  logic         edge_hit;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_q = cfg_if.sclk;
    st_nxt.cs_q = cfg_if.cs_n;
    // edge choice follows the invert pin
    edge_hit = cfg_if.invert ? (st_r.sclk_q & ~cfg_if.sclk) : (~st_r.sclk_q & cfg_if.sclk);
    if (cfg_if.enable && !cfg_if.cs_n && edge_hit) begin
      st_nxt.shreg = {st_r.shreg[aspc_pkg::CFG_BITS-2:0], cfg_if.sdata};
      if (st_r.cnt != aspc_pkg::CFG_CNT_FULL) begin
        st_nxt.cnt = st_r.cnt + 4'h1;
      end
    end
    // short frames are dropped so a torn write never half-updates the word
    if (!st_r.cs_q && cfg_if.cs_n) begin
      if (st_r.cnt == aspc_pkg::CFG_CNT_FULL) begin
        st_nxt.word = st_r.shreg;
      end
      st_nxt.cnt = 4'h0;
    end
    if (cfg_if.clear) begin
      st_nxt.word = aspc_pkg::CFG_RESET;
      st_nxt.shreg = aspc_pkg::CFG_RESET;
      st_nxt.cnt = 4'h0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{sclk_q: 1'b0, cs_q: 1'b1, cnt: 4'h0,
                shreg: aspc_pkg::CFG_RESET, word: aspc_pkg::CFG_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_if.word = st_r.word;

endmodule

// file: design/aspc_port_ctrl.sv
/*
  Converter digital interface control: serial result framing, read error flag, configuration
  source select, busy indicator, range decode and output bus gating.
  Assumes conversion core strobes are on clock; every pin input passes a synchroniser first.
*/
`timescale 1ns/1ps
module aspc_port_ctrl (
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  input  wire logic                          serial_parallel_sel,
  input  wire logic                          clock_source_sel,
  input  wire logic                          frame_polarity_sel,
  input  wire logic                          clk_invert_sel,
  input  wire logic                          read_during_conv_sel,
  input  wire logic                          bipolar_sel,
  input  wire logic                          range_wide_sel,
  input  wire logic                          cs_n,
  input  wire logic                          rd_n,
  input  wire logic                          dev_reset,
  input  wire logic                          serial_result_clk_in,
  input  wire logic [4:0]                    pin_hi_in,
  input  wire logic                          conv_start,
  input  wire logic                          conv_done,
  input  wire logic                          result_load,
  input  wire logic [aspc_pkg::RES_BITS-1:0] conv_result,
  output logic                               busy,
  output logic                               frame_sync,
  output logic                               serial_result_out,
  output logic                               serial_result_out_oe_n,
  output logic                               serial_result_clk_out,
  output logic                               serial_result_clk_oe_n,
  output logic                               read_incomplete_flag,
  output logic [aspc_pkg::RES_BITS-1:0]      data_out,
  output logic [aspc_pkg::RES_BITS-1:0]      data_oe_n,
  output aspc_pkg::aspc_range_type           range_sel,
  output logic                               read_after_conv,
  output logic                               conv_abort,
  output logic [aspc_pkg::CFG_BITS-1:0]      cfg_word
);

  typedef struct packed {
    aspc_pkg::aspc_rd_state_type   rd_st;
    logic [aspc_pkg::RES_BITS-1:0] shreg;
    logic [aspc_pkg::RES_BITS-1:0] result;
    logic [4:0]                    cnt;
    logic [1:0]                    div;
    logic                          mclk;
    logic                          sclk_q;
    logic                          read_q;
    logic                          rst_q;
    logic                          busy;
    logic                          busy_hold;
    logic                          frame;
    logic                          sdo;
    logic                          sdo_oe_n;
    logic                          mclk_oe_n;
    logic                          err;
    logic                          abort;
    logic [aspc_pkg::RES_BITS-1:0] bus;
    logic [aspc_pkg::RES_BITS-1:0] bus_oe_n;
    aspc_pkg::aspc_range_type      range;
    logic                          rac;
  } aspc_port_type;

  aspc_port_type                  st_r;
  aspc_port_type                  st_nxt;
  logic [aspc_pkg::SYNC_BITS-1:0] pins_async;
  logic [aspc_pkg::SYNC_BITS-1:0] pins;
  logic                           serial_mode;
  logic                           slave_mode;
  logic                           master_mode;
  logic                           hw_cfg;
  logic                           pol_eff;
  logic                           rdc_eff;
  logic                           read_en;
  logic                           sclk_gated;
  logic                           sclk_edge;
  logic                           rst_fall;
  logic                           master_go;
  logic                           mclk_fall;
  logic [aspc_pkg::RES_BITS-1:0]  load_word;
  logic [aspc_pkg::RES_BITS-1:0]  bus_val;
  logic [aspc_pkg::RES_BITS-1:0]  bus_en_n;

  aspc_cfg_if cfg_if ();

  assign pins_async = {pin_hi_in[4:1], serial_result_clk_in, dev_reset, rd_n, cs_n,
                       range_wide_sel, bipolar_sel, read_during_conv_sel, clk_invert_sel,
                       frame_polarity_sel, clock_source_sel, serial_parallel_sel};

  // every outside pin is resynchronised before use
  aspc_sync #(
    .WIDTH (aspc_pkg::SYNC_BITS),
    .INIT  (aspc_pkg::SYNC_RESET)
  ) u_sync (
    .clock    (clock),
    .reset_n  (reset_n),
    .async_in (pins_async),
    .sync_out (pins)
  );

  aspc_cfg_port u_cfg (
    .clock   (clock),
    .reset_n (reset_n),
    .cfg_if  (cfg_if.cfg)
  );

  assign serial_mode = pins[aspc_pkg::SY_SERPAR];
  assign slave_mode  = serial_mode & pins[aspc_pkg::SY_CLKSRC];
  assign master_mode = serial_mode & ~pins[aspc_pkg::SY_CLKSRC];
  assign hw_cfg      = pins[aspc_pkg::SY_CFGSRC];
  assign read_en     = ~pins[aspc_pkg::SY_CS_N] & ~pins[aspc_pkg::SY_RD_N];

  // config port sees its own select only; chip select does not gate it
  assign cfg_if.sclk   = pins[aspc_pkg::SY_CFGCLK];
  assign cfg_if.sdata  = pins[aspc_pkg::SY_CFGDAT];
  assign cfg_if.cs_n   = pins[aspc_pkg::SY_CFGCS_N];
  assign cfg_if.enable = serial_mode & ~hw_cfg;
  assign cfg_if.invert = pins[aspc_pkg::SY_INV];
  assign cfg_if.clear  = rst_fall;

  always_comb begin
    st_nxt = st_r;
    load_word = st_r.result;
    bus_val = '0;
    bus_en_n = '1;
    // pin or serial word source
    pol_eff = hw_cfg ? pins[aspc_pkg::SY_POL] : cfg_if.word[aspc_pkg::CFG_POL_POS];
    rdc_eff = hw_cfg ? pins[aspc_pkg::SY_RDC] : cfg_if.word[aspc_pkg::CFG_RDC_POS];
    // range code is just {bipolar, wide}
    if (hw_cfg || !serial_mode) begin
      st_nxt.range = aspc_pkg::aspc_range_type'({pins[aspc_pkg::SY_BIPOLAR],
                                                 pins[aspc_pkg::SY_WIDE]});
    end else begin
      st_nxt.range = aspc_pkg::aspc_range_type'(
        {cfg_if.word[aspc_pkg::CFG_BIPOLAR_POS], cfg_if.word[aspc_pkg::CFG_WIDE_POS]});
    end
    st_nxt.rac = ~rdc_eff;

    // slave clock only counts while chip select is low
    sclk_gated = pins[aspc_pkg::SY_SCLK] & ~pins[aspc_pkg::SY_CS_N];
    st_nxt.sclk_q = sclk_gated;
    sclk_edge = pins[aspc_pkg::SY_INV] ? (st_r.sclk_q & ~sclk_gated)
                                       : (~st_r.sclk_q & sclk_gated);
    st_nxt.read_q = read_en;

    // reset pin: abort while high, clear on release
    st_nxt.rst_q = pins[aspc_pkg::SY_RESET];
    st_nxt.abort = pins[aspc_pkg::SY_RESET];
    rst_fall = st_r.rst_q & ~pins[aspc_pkg::SY_RESET];

    st_nxt.err = 1'b0;
    if (result_load) begin
      st_nxt.result = conv_result;
      load_word = conv_result;
    end

    // busy rises on start, falls once the result register is loaded
    if (conv_start) begin
      st_nxt.busy = 1'b1;
    end else if (result_load) begin
      // master read-after-convert keeps busy over the readout
      st_nxt.busy_hold = master_mode & ~rdc_eff;
      st_nxt.busy = master_mode & ~rdc_eff;
    end

    // master clock runs free during a readout; half period is MCLK_HALF+1 cycles
    mclk_fall = 1'b0;
    if (st_r.rd_st == aspc_pkg::RD_MASTER) begin
      if (st_r.div == aspc_pkg::MCLK_HALF) begin
        st_nxt.div = 2'h0;
        st_nxt.mclk = ~st_r.mclk;
        mclk_fall = st_r.mclk;
      end else begin
        st_nxt.div = st_r.div + 2'h1;
      end
    end else begin
      st_nxt.div = 2'h0;
      st_nxt.mclk = 1'b0;
    end

    // read-after-convert starts on load, read-during-convert on the next start
    master_go = master_mode & ((result_load & ~rdc_eff) | (conv_start & rdc_eff));

    case (st_r.rd_st)
      aspc_pkg::RD_IDLE: begin
        st_nxt.frame = pol_eff;
        if (master_go) begin
          st_nxt.rd_st = aspc_pkg::RD_MASTER;
          st_nxt.shreg = load_word;
          st_nxt.sdo = load_word[aspc_pkg::RES_BITS-1];
          st_nxt.cnt = 5'h00;
          st_nxt.frame = ~pol_eff;
        end else if (slave_mode && read_en && !st_r.read_q) begin
          st_nxt.rd_st = aspc_pkg::RD_SLAVE;
          st_nxt.shreg = st_r.result;
          st_nxt.sdo = st_r.result[aspc_pkg::RES_BITS-1];
          st_nxt.cnt = 5'h00;
        end
      end
      aspc_pkg::RD_MASTER: begin
        st_nxt.frame = ~pol_eff;
        if (mclk_fall) begin
          if (st_r.cnt == aspc_pkg::RES_CNT_LAST) begin
            st_nxt.rd_st = aspc_pkg::RD_IDLE;
            st_nxt.frame = pol_eff;
            st_nxt.busy_hold = 1'b0;
            if (st_r.busy_hold && !conv_start) begin
              st_nxt.busy = 1'b0;
            end
          end else begin
            st_nxt.cnt = st_r.cnt + 5'h01;
            st_nxt.shreg = {st_r.shreg[aspc_pkg::RES_BITS-2:0], 1'b0};
            st_nxt.sdo = st_r.shreg[aspc_pkg::RES_BITS-2];
          end
        end
      end
      aspc_pkg::RD_SLAVE: begin
        st_nxt.frame = pol_eff;
        if (conv_done) begin
          // pending data is lost; a cut read never resumes mid-word
          st_nxt.rd_st = aspc_pkg::RD_IDLE;
          st_nxt.err = 1'b1;
        end else if (sclk_edge) begin
          if (st_r.cnt == aspc_pkg::RES_CNT_LAST) begin
            st_nxt.rd_st = aspc_pkg::RD_IDLE;
          end else begin
            st_nxt.cnt = st_r.cnt + 5'h01;
            st_nxt.shreg = {st_r.shreg[aspc_pkg::RES_BITS-2:0], 1'b0};
            st_nxt.sdo = st_r.shreg[aspc_pkg::RES_BITS-2];
          end
        end
      end
      default: begin
        st_nxt.rd_st = aspc_pkg::RD_IDLE;
      end
    endcase

    if (!serial_mode) begin
      st_nxt.rd_st = aspc_pkg::RD_IDLE;
      st_nxt.busy_hold = 1'b0;
    end

    // serial data pin driven only under chip select and read
    st_nxt.sdo_oe_n = ~(serial_mode & read_en);
    st_nxt.mclk_oe_n = ~master_mode;

    // parallel word, or in serial slave mode only the error flag on the bit 11 pin
    if (!serial_mode) begin
      bus_val = st_nxt.result;
      bus_en_n = {aspc_pkg::RES_BITS{~read_en}};
    end else if (slave_mode) begin
      bus_val[aspc_pkg::PIN_HI_BASE] = st_nxt.err;
      bus_en_n[aspc_pkg::PIN_HI_BASE] = 1'b0;
    end

    if (pins[aspc_pkg::SY_RESET]) begin
      // conversion abort; no readout survives it
      st_nxt.rd_st = aspc_pkg::RD_IDLE;
      st_nxt.busy = 1'b0;
      st_nxt.busy_hold = 1'b0;
    end
    if (rst_fall) begin
      st_nxt.result = aspc_pkg::RES_RESET;
      st_nxt.shreg = aspc_pkg::RES_RESET;
      st_nxt.sdo = 1'b0;
      bus_val = aspc_pkg::RES_RESET;
    end
    st_nxt.bus = bus_val;
    st_nxt.bus_oe_n = bus_en_n;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{rd_st: aspc_pkg::RD_IDLE, shreg: aspc_pkg::RES_RESET,
                result: aspc_pkg::RES_RESET, cnt: 5'h00, div: 2'h0, mclk: 1'b0,
                sclk_q: 1'b0, read_q: 1'b0, rst_q: 1'b0, busy: 1'b0, busy_hold: 1'b0,
                frame: 1'b0, sdo: 1'b0, sdo_oe_n: 1'b1, mclk_oe_n: 1'b1, err: 1'b0,
                abort: 1'b0, bus: aspc_pkg::RES_RESET, bus_oe_n: 16'hFFFF,
                range: aspc_pkg::RANGE_0_5, rac: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  // upper pins: data bits in parallel mode, flag or inputs in serial mode
  genvar gi;
  generate
    for (gi = aspc_pkg::PIN_HI_BASE; gi < aspc_pkg::RES_BITS; gi++) begin : g_hi
      assign data_out[gi]  = st_r.bus[gi];
      assign data_oe_n[gi] = st_r.bus_oe_n[gi];
    end
  endgenerate

  assign data_out[aspc_pkg::PIN_HI_BASE-1:0]  = st_r.bus[aspc_pkg::PIN_HI_BASE-1:0];
  assign data_oe_n[aspc_pkg::PIN_HI_BASE-1:0] = st_r.bus_oe_n[aspc_pkg::PIN_HI_BASE-1:0];
  assign busy                   = st_r.busy;
  assign frame_sync             = st_r.frame;
  assign serial_result_out      = st_r.sdo;
  assign serial_result_out_oe_n = st_r.sdo_oe_n;
  assign serial_result_clk_out  = st_r.mclk;
  assign serial_result_clk_oe_n = st_r.mclk_oe_n;
  assign read_incomplete_flag   = st_r.err;
  assign range_sel              = st_r.range;
  assign read_after_conv        = st_r.rac;
  assign conv_abort             = st_r.abort;
  assign cfg_word               = cfg_if.word;

endmodule

// file: verif/aspc_host_model.sv
/*
  Host controller model: drives chip select, read, the slave data clock and the serial
  configuration port, and collects slave readout bits.
  Assumes the bench calls its tasks just after a falling clock edge.
*/
`timescale 1ns/1ps
module aspc_host_model (
  input  wire logic clock,
  input  wire logic inv,
  input  wire logic sdo,
  output logic      cs_n,
  output logic      rd_n,
  output logic      sclk,
  output logic      cfg_dat,
  output logic      cfg_clk,
  output logic      cfg_cs_n
);
  logic [15:0] rx;
  event        rx_done;

  initial begin
    {cs_n, rd_n, cfg_cs_n} = 3'h7;
    {sclk, cfg_clk, cfg_dat} = 3'h0;
  end

  // half of the 200 ns link period
  task automatic half();
    repeat (4) @(negedge clock);
  endtask

  task automatic cfg_write(input logic [7:0] w);
    cfg_clk = inv;
    cfg_cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      cfg_dat = w[i];
      half();
      cfg_clk = ~inv;
      half();
      cfg_clk = inv;
    end
    half();
    cfg_cs_n = 1'b1;
    // released line: no stale bit left for the device to trust
    cfg_dat = ~cfg_dat;
  endtask

  task automatic par_read();
    {cs_n, rd_n} = 2'h0;
    repeat (8) @(negedge clock);
    {cs_n, rd_n} = 2'h3;
    repeat (6) @(negedge clock);
  endtask

  // clock stands at its inactive level outside a frame
  task automatic slave_read(input int n);
    sclk = inv;
    {cs_n, rd_n} = 2'h0;
    half();
    half();
    for (int i = 15; i > 15 - n; i--) begin
      rx[i] = sdo;
      sclk = ~inv;
      half();
      sclk = inv;
      half();
    end
    {cs_n, rd_n} = 2'h3;
    if (n == 16) -> rx_done;
    // release must be seen before the next read can start
    half();
  endtask
endmodule

// file: verif/aspc_port_ctrl_checker.sv
/*
  Concurrent checks on the port controller's top-level pins.
  Assumes pin inputs reach the logic within a few synchroniser cycles.
*/
`timescale 1ns/1ps
module aspc_port_ctrl_checker (
  input wire logic                          clock,
  input wire logic                          reset_n,
  input wire logic                          serial_parallel_sel,
  input wire logic                          clock_source_sel,
  input wire logic                          bipolar_sel,
  input wire logic                          range_wide_sel,
  input wire logic                          cs_n,
  input wire logic                          rd_n,
  input wire logic                          dev_reset,
  input wire logic [4:0]                    pin_hi_in,
  input wire logic                          conv_start,
  input wire logic                          conv_done,
  input wire logic                          result_load,
  input wire logic                          busy,
  input wire logic                          frame_sync,
  input wire logic                          read_incomplete_flag,
  input wire logic [aspc_pkg::RES_BITS-1:0] data_oe_n,
  input wire aspc_pkg::aspc_range_type      range_sel,
  input wire logic                          conv_abort,
  input wire logic [aspc_pkg::CFG_BITS-1:0] cfg_word
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  range_decode_a:
    assert property ((!serial_parallel_sel && $stable({bipolar_sel, range_wide_sel}))[*6]
      |-> range_sel == {bipolar_sel, range_wide_sel}) else $error("range decode wrong");
  bus_off_a:
    assert property ((!serial_parallel_sel && (cs_n || rd_n))[*6] |-> data_oe_n == 16'hFFFF)
      else $error("bus driven while deselected");
  bus_on_a:
    assert property ((!serial_parallel_sel && !cs_n && !rd_n)[*6] |-> data_oe_n == 16'h0000)
      else $error("bus not driven on read");
  busy_start_a:
    assert property (conv_start && !conv_abort |-> ##[1:2] busy) else $error("busy missing");
  busy_end_a:
    assert property ($fell(busy) |-> $past(result_load) || conv_abort || $changed(frame_sync))
      else $error("busy fell early");
  abort_follow_a:
    assert property ($stable(dev_reset)[*5] |-> conv_abort == dev_reset)
      else $error("abort does not follow reset pin");
  busy_abort_a:
    assert property (conv_abort |=> !busy) else $error("busy during abort");
  err_pulse_a:
    assert property (read_incomplete_flag |=> !read_incomplete_flag) else $error("error too long");
  err_cause_a:
    assert property (read_incomplete_flag |-> ($past(conv_done) || $past(conv_done, 2))
      && serial_parallel_sel && clock_source_sel) else $error("error without cause");
  cfg_hold_a:
    assert property (($stable(pin_hi_in[4]) && $stable(dev_reset))[*6] |-> $stable(cfg_word))
      else $error("config word changed unprompted");
endmodule

bind aspc_port_ctrl aspc_port_ctrl_checker u_aspc_port_ctrl_checker (.clock, .reset_n,
  .serial_parallel_sel, .clock_source_sel, .bipolar_sel, .range_wide_sel, .cs_n, .rd_n,
  .dev_reset, .pin_hi_in, .conv_start, .conv_done, .result_load, .busy, .frame_sync,
  .read_incomplete_flag, .data_oe_n, .range_sel, .conv_abort, .cfg_word);

// file: verif/aspc_port_ctrl_test.sv
/*
  Self-checking bench: emulates the converter core and mode pins, drives the host side
  through the host model, and compares results against an expectation queue.
  Assumes the 40 MHz clock and the design's pin synchronisers.
*/
`timescale 1ns/1ps
module aspc_port_ctrl_test;
  logic clock = 1'b0;
  logic reset_n, serial_parallel_sel, clock_source_sel, frame_polarity_sel, clk_invert_sel;
  logic read_during_conv_sel, bipolar_sel, range_wide_sel, dev_reset, config_source_sel;
  logic cs_n, rd_n, sclk_in, cfg_dat, cfg_clk, cfg_cs_n, conv_start, conv_done, result_load;
  logic busy, frame_sync, sdo, sclk_out, rd_err, conv_abort, sdo_oe_n, clk_oe_n, rac;
  logic [15:0] conv_result, data_out, data_oe_n, v, v2;
  logic [7:0]  cfg_word, w;
  logic [15:0] exp_q[$];
  aspc_pkg::aspc_range_type range_sel;
  int error_cnt = 0, compares = 0, cyc = 0;
  int seed = 32'hB3D1E570;

  always #12.5 clock = ~clock;

  aspc_port_ctrl u_aspc_port_ctrl (.clock, .reset_n, .serial_parallel_sel, .clock_source_sel,
    .frame_polarity_sel, .clk_invert_sel, .read_during_conv_sel, .bipolar_sel, .range_wide_sel,
    .cs_n, .rd_n, .dev_reset, .serial_result_clk_in(sclk_in),
    .pin_hi_in({cfg_cs_n, cfg_clk, cfg_dat, config_source_sel, 1'b0}), .conv_start, .conv_done,
    .result_load, .conv_result, .busy, .frame_sync, .serial_result_out(sdo),
    .serial_result_out_oe_n(sdo_oe_n), .serial_result_clk_out(sclk_out),
    .serial_result_clk_oe_n(clk_oe_n), .read_incomplete_flag(rd_err), .data_out, .data_oe_n,
    .range_sel, .read_after_conv(rac), .conv_abort, .cfg_word);

  aspc_host_model u_aspc_host_model (.clock, .inv(clk_invert_sel), .sdo, .cs_n, .rd_n,
    .sclk(sclk_in), .cfg_dat, .cfg_clk, .cfg_cs_n);

  task automatic finish_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [15:0] got);
    logic [15:0] exp;
    exp = exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX;
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // core emulation: start, complete, load
  task automatic convert(input logic [15:0] r);
    conv_start = 1'b1;
    @(negedge clock) conv_start = 1'b0;
    repeat (10) @(negedge clock);
    {conv_done, result_load} = 2'h3;
    conv_result = r;
    @(negedge clock) {conv_done, result_load} = 2'h0;
    repeat (300) if (busy === 1'b1) @(negedge clock);
  endtask

  // {serial, slave clock, pin config, inverted edges}
  task automatic set_mode(input logic [3:0] m);
    {serial_parallel_sel, clock_source_sel, config_source_sel, clk_invert_sel} = m;
    repeat (8) @(negedge clock);
  endtask

  task automatic read_master(input logic act);
    v = 16'($random(seed));
    exp_q.push_back({13'h0000, 2'h2, act});
    exp_q.push_back(v);
    convert(v);
    repeat (4) @(negedge clock);
  endtask

  initial begin
    wait (reset_n === 1'b1);
    @(negedge clock);
    fork
      forever @(range_sel) check("range", {14'h0000, range_sel});
      forever @(cfg_word) check("cfg word", {8'h00, cfg_word});
      forever @(posedge rd_err) check("read error", {15'h0000, rd_err});
      forever begin
        @(u_aspc_host_model.rx_done) check("slave word", u_aspc_host_model.rx);
        check("data enable", {15'h0000, sdo_oe_n});
      end
      forever begin
        @(negedge data_oe_n[0]);
        @(negedge clock);
        check("bus enable", data_oe_n);
        check("parallel word", data_out);
      end
      forever begin
        repeat (16) @(posedge sclk_out) v2 = {v2[14:0], sdo};
        check("frame", {13'h0000, rac, clk_oe_n, frame_sync});
        check("master word", v2);
      end
    join
  end

  initial begin
    {reset_n, serial_parallel_sel, clock_source_sel, frame_polarity_sel, clk_invert_sel} = 5'h00;
    {read_during_conv_sel, bipolar_sel, range_wide_sel, dev_reset, config_source_sel} = 5'h01;
    {conv_start, conv_done, result_load} = 3'h0;
    conv_result = 16'h0000;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    for (int i = 1; i <= 4; i++) begin
      {bipolar_sel, range_wide_sel} = 2'(i);
      exp_q.push_back(16'(i % 4));
      repeat (8) @(negedge clock);
    end
    v = 16'($random(seed));
    exp_q.push_back(16'h0000);
    exp_q.push_back(v);
    convert(v);
    u_aspc_host_model.par_read();
    // pin polarity high, pin config: frame active low
    frame_polarity_sel = 1'b1;
    set_mode(4'hA);
    read_master(1'b0);
    // read-during-convert pin: previous word goes out under the next conversion
    read_during_conv_sel = 1'b1;
    repeat (4) @(negedge clock);
    exp_q.push_back(16'h0000);
    exp_q.push_back(v);
    convert(16'($random(seed)));
    repeat (70) @(negedge clock);
    // serial word with polarity bit low overrides the pin
    set_mode(4'h8);
    w = {1'b1, 3'($random(seed)), 4'h0};
    exp_q.push_back({8'h00, w});
    u_aspc_host_model.cfg_write(w);
    read_master(1'b1);
    set_mode(4'h9);
    w = {1'b1, ~w[6:4], 4'h0};
    exp_q.push_back({8'h00, w});
    u_aspc_host_model.cfg_write(w);
    set_mode(4'hD);
    v = 16'($random(seed));
    convert(v);
    exp_q.push_back(v);
    exp_q.push_back(16'h0000);
    u_aspc_host_model.slave_read(16);
    exp_q.push_back(16'h0001);
    fork
      u_aspc_host_model.slave_read(6);
      begin
        repeat (30) @(negedge clock);
        convert(16'($random(seed)));
      end
    join
    conv_start = 1'b1;
    @(negedge clock) conv_start = 1'b0;
    dev_reset = 1'b1;
    exp_q.push_back(16'h0000);
    repeat (10) @(negedge clock);
    dev_reset = 1'b0;
    repeat (10) @(negedge clock);
    set_mode(4'h0);
    exp_q.push_back(16'h0000);
    exp_q.push_back(16'h0000);
    u_aspc_host_model.par_read();
    finish_test();
  end
endmodule
